/* hw/led_dim_pkg.sv */
package led_dim_pkg;

  // Number of duty slots and width of one duty code.
  localparam int SLOT_COUNT   = 8;
  localparam int SLOT_IDX_W   = 3;
  localparam int DUTY_W       = 6;
  localparam int BYTE_W       = 8;
  localparam int PWM_STEP_W   = 6;

  // Serial byte routing: bit 7 of the first byte marks a duty transfer.
  localparam int TYPE_BIT     = 7;

  // First configuration byte field positions.
  localparam int CFG1_SENSOR_DISABLE = 6;
  localparam int CFG1_MANUAL_HI      = 5;
  localparam int CFG1_MANUAL_LO      = 3;
  localparam int CFG1_SLEEP          = 2;
  localparam int CFG1_FREEZE         = 1;
  localparam int CFG1_REVERSAL       = 0;

  // Second configuration byte field positions.
  localparam int CFG2_FEEDBACK       = 6;
  localparam int CFG2_POLARITY       = 5;
  localparam int CFG2_STRING_1       = 4;
  localparam int CFG2_STRING_2       = 3;
  localparam int CFG2_STRING_3       = 2;
  localparam int CFG2_SCALE_HI       = 1;
  localparam int CFG2_SCALE_LO       = 0;

  // Values after reset.
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [5:0] DUTY_RESET = 6'h00;
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST  = 3'h7;

  // Interval exponents: sample 2^(17+N), PWM step 2^(3+N) oscillator cycles.
  localparam int SAMPLE_EXP_BASE = 17;
  localparam int PWM_EXP_BASE    = 3;
  localparam int SAMPLE_CNT_W    = 24;
  localparam int PRESCALE_W      = 8;

  // Byte counter saturates one past the last slot so later bytes drop.
  localparam logic [3:0] BYTE_CNT_MAX = 4'h9;

endpackage

/* hw/pwm_step_gen.sv */
`timescale 1ns/1ps
// Sixty-four step PWM generator with a power-of-two step prescaler.
module pwm_step_gen #(
  parameter int EXP_BASE = 3
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         run,
  input  wire logic [1:0]                   scale,
  input  wire logic [led_dim_pkg::DUTY_W-1:0] duty,
  output logic                              pwmOut
);
  import led_dim_pkg::*;

  logic [PRESCALE_W-1:0] preCnt_q;   // Oscillator cycles within one step.
  logic [PRESCALE_W-1:0] preLast;    // Last prescaler count for this scale.
  logic [PWM_STEP_W-1:0] step_q;     // Current step of the 64-step period.
  logic                  stepTick;   // Advance the step counter.

  // The step clock is the oscillator divided by 2^(base+N).
  assign preLast  = PRESCALE_W'((32'd1 << (EXP_BASE + 32'(scale))) - 32'd1);
  assign stepTick = (preCnt_q >= preLast);

  // Prescaler; held at zero when the oscillator is stopped.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      preCnt_q <= '0;
    end else if (stepTick) begin
      preCnt_q <= '0;
    end else begin
      preCnt_q <= preCnt_q + 1'b1;
    end
  end

  // Step counter wraps naturally after 64 steps.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      step_q <= '0;
    end else if (stepTick) begin
      step_q <= step_q + 1'b1;
    end
  end

  // Code zero is off; code k is high for steps 0..k, which is k+1 steps.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (duty != '0) && (step_q <= duty);
    end
  end

endmodule

/* hw/ambient_led_dimming_ctrl.sv */
// Functional notes
// - Sensor level picks one of eight duty slots.
// - Sample refresh periodic, period from scale field.
// - Freeze bit keeps current slot selection.
// - Code 0 off; code k gives k+1/64.
// - Reversal bit mirrors sensor-to-slot mapping.
// - MSB first, sample on shift rise, commit on request.
// - First then second config byte; single means first.
// - Duty bytes load slots 0..7; ninth onward dropped.
// - First config byte field layout.
// - Second config byte field layout.
// - Request high: device shifts out one-hot selected slot.
// - Sensor disable selects slot from manual level.
// - Sleep stops oscillator, sensor supply; slots kept.
// - Reset slot 0; sleep exit restarts 0 or 7.
// - Sample interval 2^(17+N) oscillator cycles.
// - PWM step clock oscillator over 2^(3+N).
// - String enables drive switches; polarity flips all.
// - Lowest enabled feedback input active; none gives 1.
// - Active-low reset clears config and all slots.
`timescale 1ns/1ps
module ambient_led_dimming_ctrl #(
  parameter int SAMPLE_EXP = led_dim_pkg::SAMPLE_EXP_BASE,
  parameter int PWM_EXP    = led_dim_pkg::PWM_EXP_BASE
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              activeLowResetN,
  input  wire logic                              shiftClk,
  input  wire logic                              requestLine,
  input  wire logic                              serialDataIn,
  output logic                                   serialDataOut,
  output logic                                   serialDataOeN,
  input  wire logic [led_dim_pkg::SLOT_IDX_W-1:0] ambientSenseInput,
  output logic                                   pwmOut,
  output logic [2:0]                             stringSwitchOutputs,
  output logic [2:0]                             feedbackInputs,
  output logic                                   feedbackFlag,
  output logic                                   sensorSupplyEn,
  output logic                                   oscRunning,
  output logic [led_dim_pkg::SLOT_IDX_W-1:0]     selectedSlot
);
  import led_dim_pkg::*;

  // Two-stage synchronisers for every pin that is not on clk.
  logic                  pinRstN_q1, pinRstN_q2;
  logic                  sck_q1, sck_q2, sck_q3;
  logic                  req_q1, req_q2, req_q3;
  logic                  din_q1, din_q2;
  logic [SLOT_IDX_W-1:0] sense_q1, sense_q2;

  logic                  coreRst;     // Pin reset or system reset.
  logic                  sckRise;     // Shift clock rising edge.
  logic                  sckFall;     // Shift clock falling edge.
  logic                  reqRise;     // Request line rising edge.
  logic                  reqFall;     // Request line falling edge.

  // Receive path.
  logic [BYTE_W-1:0]     shift_q;     // Incoming shift register.
  logic [2:0]            bitCnt_q;    // Bits of the current byte.
  logic [3:0]            byteCnt_q;   // Bytes in this write transfer.
  logic [BYTE_W-1:0]     stage_q [SLOT_COUNT]; // Bytes awaiting commit.
  logic [BYTE_W-1:0]     byteDone;    // Byte completed this cycle.

  // Configuration and duty storage.
  logic [BYTE_W-1:0]     cfg1_q;      // First configuration byte.
  logic [BYTE_W-1:0]     cfg2_q;      // Second configuration byte.
  logic [DUTY_W-1:0]     slot_q [SLOT_COUNT]; // Duty slots 0..7.

  // Selection, sampling and readback.
  logic [SLOT_IDX_W-1:0] sel_q;       // Selected duty slot.
  logic [SAMPLE_CNT_W-1:0] sampleCnt_q; // Oscillator cycles in interval.
  logic [SAMPLE_CNT_W-1:0] sampleLast;  // Last count of the interval.
  logic                  sampleTick;  // Interval elapsed.
  logic [BYTE_W-1:0]     readShift_q; // Outgoing one-hot byte.
  logic                  driving_q;   // Data pin turned to output.

  // Decoded fields.
  logic                  sensorOff, sleepOn, freezeOn, reversalOn;
  logic                  polarityOn;
  logic [2:0]            manualLevel, strEn;
  logic [1:0]            scale;
  logic [SLOT_IDX_W-1:0] sensedSlot;

  // Synchronisers; the first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      pinRstN_q1 <= 1'b0;
      pinRstN_q2 <= 1'b0;
      sck_q1     <= 1'b0;
      sck_q2     <= 1'b0;
      sck_q3     <= 1'b0;
      req_q1     <= 1'b0;
      req_q2     <= 1'b0;
      req_q3     <= 1'b0;
      din_q1     <= 1'b0;
      din_q2     <= 1'b0;
      sense_q1   <= '0;
      sense_q2   <= '0;
    end else begin
      pinRstN_q1 <= activeLowResetN;
      pinRstN_q2 <= pinRstN_q1;
      sck_q1     <= shiftClk;
      sck_q2     <= sck_q1;
      sck_q3     <= sck_q2;
      req_q1     <= requestLine;
      req_q2     <= req_q1;
      req_q3     <= req_q2;
      din_q1     <= serialDataIn;
      din_q2     <= din_q1;
      sense_q1   <= ambientSenseInput;
      sense_q2   <= sense_q1;
    end
  end

  // The pin reset is folded in after synchronising; edges look at stage 2+.
  assign coreRst = rst || !pinRstN_q2;
  assign sckRise = sck_q2 && !sck_q3;
  assign sckFall = !sck_q2 && sck_q3;
  assign reqRise = req_q2 && !req_q3;
  assign reqFall = !req_q2 && req_q3;

  // Field decode of both configuration bytes.
  assign sensorOff   = cfg1_q[CFG1_SENSOR_DISABLE];
  assign manualLevel = cfg1_q[CFG1_MANUAL_HI:CFG1_MANUAL_LO];
  assign sleepOn     = cfg1_q[CFG1_SLEEP];
  assign freezeOn    = cfg1_q[CFG1_FREEZE];
  assign reversalOn  = cfg1_q[CFG1_REVERSAL];
  assign feedbackFlag = cfg2_q[CFG2_FEEDBACK];
  assign polarityOn  = cfg2_q[CFG2_POLARITY];
  assign strEn       = {cfg2_q[CFG2_STRING_3], cfg2_q[CFG2_STRING_2],
                        cfg2_q[CFG2_STRING_1]};
  assign scale       = cfg2_q[CFG2_SCALE_HI:CFG2_SCALE_LO];

  // The byte that completes with this rising shift edge, MSB first.
  assign byteDone = {shift_q[BYTE_W-2:0], din_q2};

  // Receive shift register and bit counter; a write only happens while
  // the request line is low, so the readback phase shifts nothing in.
  always_ff @(posedge clk) begin
    if (coreRst || req_q2) begin
      shift_q  <= '0;
      bitCnt_q <= '0;
    end else if (sckRise) begin
      shift_q  <= byteDone;
      bitCnt_q <= bitCnt_q + 1'b1;
    end
  end

  // Byte counter restarts whenever the request line falls.
  always_ff @(posedge clk) begin
    if (coreRst || reqFall) begin
      byteCnt_q <= '0;
    end else if (!req_q2 && sckRise && (bitCnt_q == 3'h7) &&
                 (byteCnt_q != BYTE_CNT_MAX)) begin
      byteCnt_q <= byteCnt_q + 1'b1;
    end
  end

  // Staging: the first eight bytes are kept; later ones are dropped.
  // Staging lets a burst be committed only on the request edge.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        stage_q[i] <= '0;
      end
    end else if (!req_q2 && sckRise && (bitCnt_q == 3'h7) &&
                 (byteCnt_q < 4'(SLOT_COUNT))) begin
      stage_q[byteCnt_q[2:0]] <= byteDone;
    end
  end

  // Commit of configuration bytes on the request rising edge. Bit 7 of
  // the first byte decides the kind of the whole transfer. Bytes three
  // and four are for factory use and, like any later ones, are ignored.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      cfg1_q <= CFG_RESET;
      cfg2_q <= CFG_RESET;
    end else if (reqRise && (byteCnt_q != '0) &&
                 !stage_q[0][TYPE_BIT]) begin
      cfg1_q <= stage_q[0];
      if (byteCnt_q >= 4'h2) begin
        cfg2_q <= stage_q[1];
      end
    end
  end

  // Commit of duty bytes: only slots covered by the burst are loaded.
  // Slots survive sleep; only reset clears them.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot_q[i] <= DUTY_RESET;
      end
    end else if (reqRise && (byteCnt_q != '0) &&
                 stage_q[0][TYPE_BIT]) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        if (4'(i) < byteCnt_q) begin
          slot_q[i] <= stage_q[i][DUTY_W-1:0];
        end
      end
    end
  end

  // Sample interval is 2^(base+N) oscillator cycles.
  assign sampleLast = SAMPLE_CNT_W'((32'd1 << (SAMPLE_EXP + 32'(scale)))
                                    - 32'd1);
  assign sampleTick = (sampleCnt_q >= sampleLast);

  // Interval counter; halted and cleared while asleep as the oscillator
  // is stopped then.
  always_ff @(posedge clk) begin
    if (coreRst || sleepOn || sampleTick) begin
      sampleCnt_q <= '0;
    end else begin
      sampleCnt_q <= sampleCnt_q + 1'b1;
    end
  end

  // Sensor level mapped through the reversal bit.
  assign sensedSlot = reversalOn ? (SLOT_LAST - sense_q2)
                                 : sense_q2;

  // Slot selection only moves at a sample tick, never continuously.
  // Sleep reinitialises it; the first cycle after wake-up does so again
  // with the mapping then in force, since the waking command may flip it.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      sel_q <= SLOT_FIRST;
    end else if (sleepOn || !oscRunning) begin
      sel_q <= reversalOn ? SLOT_LAST : SLOT_FIRST;
    end else if (sampleTick && !freezeOn) begin
      if (sensorOff) begin
        sel_q <= manualLevel;
      end else begin
        sel_q <= sensedSlot;
      end
    end
  end

  // Readback: the request rise loads the one-hot byte and turns the pin
  // to output; falling shift edges present the next bit, MSB first, so
  // the host samples each bit on its rising edge.
  always_ff @(posedge clk) begin
    if (coreRst || !req_q2) begin
      readShift_q <= '0;
      driving_q   <= 1'b0;
    end else if (reqRise) begin
      readShift_q <= BYTE_W'(1) << sel_q;
      driving_q   <= 1'b1;
    end else if (sckFall) begin
      readShift_q <= {readShift_q[BYTE_W-2:0], 1'b0};
    end
  end

  // Data pin: enable is low while the device drives it.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      serialDataOut <= 1'b0;
      serialDataOeN <= 1'b1;
    end else begin
      serialDataOut <= readShift_q[BYTE_W-1];
      serialDataOeN <= !driving_q;
    end
  end

  // String switches follow the enables, all flipped by the polarity bit.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      stringSwitchOutputs <= '0;
    end else begin
      stringSwitchOutputs <= strEn ^ {3{polarityOn}};
    end
  end

  // Only the lowest-numbered enabled string's feedback input is active;
  // with none enabled, input 1 stays active so regulation never floats.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      feedbackInputs <= 3'h1;
    end else if (strEn[0] || (strEn == 3'h0)) begin
      feedbackInputs <= 3'h1;
    end else if (strEn[1]) begin
      feedbackInputs <= 3'h2;
    end else begin
      feedbackInputs <= 3'h4;
    end
  end

  // Oscillator and sensor supply run whenever the device is awake.
  always_ff @(posedge clk) begin
    if (coreRst) begin
      oscRunning     <= 1'b0;
      sensorSupplyEn <= 1'b0;
      selectedSlot   <= SLOT_FIRST;
    end else begin
      oscRunning     <= !sleepOn;
      sensorSupplyEn <= !sleepOn;
      selectedSlot   <= sel_q;
    end
  end

  // PWM engine driven from the selected slot's code.
  pwm_step_gen #(
    .EXP_BASE (PWM_EXP)
  ) u_pwm (
    .clk    (clk),
    .rst    (coreRst),
    .run    (!sleepOn),
    .scale  (scale),
    .duty   (slot_q[sel_q]),
    .pwmOut (pwmOut)
  );

endmodule

/* tb/led_dim_checker.sv */
`timescale 1ns/1ps
// Watches the dimming controller's pins for timing and state relations.
module led_dim_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       requestLine,
  input wire logic       serialDataOeN,
  input wire logic       pwmOut,
  input wire logic [2:0] stringSwitchOutputs,
  input wire logic [2:0] feedbackInputs,
  input wire logic       sensorSupplyEn,
  input wire logic       oscRunning,
  input wire logic [2:0] selectedSlot
);
  // All relations live in the one clock domain of the controller.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  reset_state_a: assert property (
    $fell(rst) |-> selectedSlot == 3'h0 && !pwmOut)
    else $error("Selection or output not cleared by reset.");
  wake_slot_a: assert property (
    $rose(oscRunning) |-> selectedSlot == 3'h0 || selectedSlot == 3'h7)
    else $error("Selection did not restart at an end slot.");
  sleep_pwm_a: assert property (
    !oscRunning |-> !pwmOut)
    else $error("PWM output active while asleep.");
  supply_osc_a: assert property (
    sensorSupplyEn == oscRunning)
    else $error("Sensor supply and oscillator disagree.");
  // One cycle of slack lets the forced sleep slot settle first.
  sleep_hold_a: assert property (
    !oscRunning [*3] |-> $stable(selectedSlot))
    else $error("Selection moved while asleep.");
  oe_release_a: assert property (
    !requestLine [*8] |-> serialDataOeN)
    else $error("Data pin still driven in write phase.");
  oe_answer_a: assert property (
    $rose(requestLine) |-> ##[3:8] !serialDataOeN)
    else $error("Data pin not turned round after request.");
  fb_onehot_a: assert property (
    $onehot(feedbackInputs))
    else $error("Feedback selection not one-hot.");
  // With the second input active, strings one and two must differ.
  fb_two_a: assert property (
    feedbackInputs == 3'h2 |->
      stringSwitchOutputs[0] != stringSwitchOutputs[1])
    else $error("Second feedback input chosen wrongly.");
  fb_three_a: assert property (
    feedbackInputs == 3'h4 |-> stringSwitchOutputs[0] ==
      stringSwitchOutputs[1] && stringSwitchOutputs[2] !=
      stringSwitchOutputs[1])
    else $error("Third feedback input chosen wrongly.");
endmodule

/* tb/serial_host_model.sv */
`timescale 1ns/1ps
// Host processor model: writes bytes and reads the selection back.
module serial_host_model (
  input  wire logic clk,
  input  wire logic dataWire,
  output logic      shiftClk,
  output logic      requestLine,
  output logic      dataBit
);
  // Pins idle low so no request edge appears out of reset.
  initial begin
    shiftClk = 1'b0;
    requestLine = 1'b0;
    dataBit = 1'b0;
  end

  // Waits n edges, then steps just past the edge so changes never race it.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sends whole bytes, MSB first, shift clock low whenever request moves.
  task automatic xfer(input logic [7:0] q[$]);
    requestLine = 1'b0;
    cyc(8);
    foreach (q[k]) begin
      for (int i = 7; i >= 0; i--) begin
        dataBit = q[k][i];
        cyc(4);
        shiftClk = 1'b1;
        cyc(4);
        shiftClk = 1'b0;
      end
    end
    cyc(2);
    requestLine = 1'b1;
    // A released line must not keep showing the last bit.
    dataBit = ~dataBit;
    cyc(12);
  endtask

  // Takes each bit just before the rising shift edge; bit 7 comes first.
  task automatic read(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      v[i] = dataWire;
      shiftClk = 1'b1;
      cyc(4);
      shiftClk = 1'b0;
      cyc(6);
    end
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the dimming controller and its serial host.
module tb_top;
  import led_dim_pkg::*;
  logic        clk, rst, activeLowResetN, dataWire;
  logic        shiftClk, requestLine, dataBit;
  logic        serialDataOut, serialDataOeN, pwmOut, feedbackFlag;
  logic        sensorSupplyEn, oscRunning;
  logic [2:0]  ambientSenseInput, stringSwitchOutputs, feedbackInputs;
  logic [2:0]  selectedSlot;
  logic [5:0]  duty [8];        // Expected slot contents.
  logic [31:0] seed = 32'hA3B4; // Fixed seed keeps runs repeatable.
  int          errCount, totalChecks, cycles;

  // The data pin carries whichever side has it enabled.
  assign dataWire = serialDataOeN ? dataBit : serialDataOut;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Short sample and step counts keep every interval within reach.
  ambient_led_dimming_ctrl #(.SAMPLE_EXP(4), .PWM_EXP(0)) i_dut (
    .clk(clk), .rst(rst), .activeLowResetN(activeLowResetN),
    .shiftClk(shiftClk), .requestLine(requestLine),
    .serialDataIn(dataWire), .serialDataOut(serialDataOut),
    .serialDataOeN(serialDataOeN), .ambientSenseInput(ambientSenseInput),
    .pwmOut(pwmOut), .stringSwitchOutputs(stringSwitchOutputs),
    .feedbackInputs(feedbackInputs), .feedbackFlag(feedbackFlag),
    .sensorSupplyEn(sensorSupplyEn), .oscRunning(oscRunning),
    .selectedSlot(selectedSlot));
  serial_host_model i_host (
    .clk(clk), .dataWire(dataWire), .shiftClk(shiftClk),
    .requestLine(requestLine), .dataBit(dataBit));

  // Xorshift source for all random stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // High clocks per period: none for code 0, else code plus one steps.
  function automatic int onClocks(input logic [5:0] k, input logic [1:0] n);
    return (k == 6'h00) ? 0 : (int'(k) + 1) << n;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Both config bytes go in one transfer, never more than two.
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
    logic [7:0] q[$];
    q = {c1, c2};
    i_host.xfer(q);
  endtask

  // Counting over a whole period makes the phase irrelevant.
  task automatic highCount(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      #1;
      n += (pwmOut === 1'b1);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The run needs about 10000 cycles; far beyond that means a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errCount++;
      tally_and_finish();
    end
  end

  initial begin
    logic [7:0]  q[$];
    logic [7:0]  v;
    logic [31:0] r;
    logic [2:0]  sv;
    int          n;
    rst = 1'b1;
    activeLowResetN = 1'b1;
    ambientSenseInput = 3'h0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    i_host.cyc(4);
    chk(selectedSlot, 0);
    chk(feedbackInputs, 1);
    chk(stringSwitchOutputs, 0);
    $display("test reset done");
    // Nine duty bytes with both extreme codes; the ninth must drop.
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      q.push_back({1'b1, r[6:0]});
    end
    q[0] = 8'h80;
    q[5] = 8'hAA;
    q[7] = 8'hFF;
    q[8] = 8'h80;
    for (int i = 0; i < 8; i++) begin
      duty[i] = q[i][5:0];
    end
    i_host.xfer(q);
    // Manual level per slot, stepping the scale field at the same time.
    for (int m = 0; m < 8; m++) begin
      cfg({2'b01, m[2:0], 3'b000}, {6'h00, m[1:0]});
      i_host.cyc(160);
      chk(selectedSlot, m);
      // Readback shows the slot selected at the request rise, so a
      // request edge with no bytes refreshes it after the change.
      q.delete();
      i_host.xfer(q);
      i_host.read(v);
      chk(v, 8'h01 << m);
      highCount(64 << m[1:0], n);
      chk(n, onClocks(duty[m], m[1:0]));
    end
    $display("test duty done");
    // Sensor following with random reversal over every string pattern.
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      cfg({7'h00, r[0]}, {1'b0, r[1], c[3:0], 2'b00});
      ambientSenseInput = r[4:2];
      i_host.cyc(40);
      chk(selectedSlot, r[0] ? 3'h7 - r[4:2] : r[4:2]);
      chk(stringSwitchOutputs, {c[0], c[1], c[2]} ^ {3{c[3]}});
      chk(feedbackInputs, c[2] ? 1 : c[1] ? 2 : c[0] ? 4 : 1);
      chk(feedbackFlag, r[1]);
    end
    $display("test sensor done");
    // Freeze must keep the slot although the sensor level moves.
    sv = selectedSlot;
    cfg(8'h02, 8'h00);
    // With reversal off, the complement maps to a slot other than the held one.
    ambientSenseInput = ~sv;
    i_host.cyc(100);
    chk(selectedSlot, sv);
    $display("test freeze done");
    // A lone byte is the first config byte: sleep with reversal.
    q = {8'h05};
    i_host.xfer(q);
    chk(oscRunning, 0);
    chk(sensorSupplyEn, 0);
    chk(pwmOut, 0);
    chk(selectedSlot, 7);
    // Waking on manual level 5 must find the slot contents intact.
    // Before the first sample tick the selection restarts at slot 0.
    cfg(8'h68, 8'h00);
    chk(selectedSlot, 0);
    i_host.cyc(40);
    highCount(64, n);
    chk(n, onClocks(duty[5], 2'h0));
    $display("test sleep done");
    // The pin reset clears all slots, so the output stays off.
    activeLowResetN = 1'b0;
    i_host.cyc(6);
    activeLowResetN = 1'b1;
    i_host.cyc(6);
    chk(selectedSlot, 0);
    cfg(8'h68, 8'h00);
    i_host.cyc(40);
    highCount(64, n);
    chk(n, 0);
    // Short bursts load only the slots they cover; slot 1 must keep its
    // code although a later one-byte burst leaves a config byte staged.
    q = {8'hBF, 8'hA0};
    i_host.xfer(q);
    cfg(8'h48, 8'h00);
    q = {8'h81};
    i_host.xfer(q);
    i_host.cyc(40);
    highCount(64, n);
    chk(n, onClocks(6'h20, 2'h0));
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule

bind ambient_led_dimming_ctrl led_dim_checker i_chk (
  .clk(clk), .rst(rst), .requestLine(requestLine),
  .serialDataOeN(serialDataOeN), .pwmOut(pwmOut),
  .stringSwitchOutputs(stringSwitchOutputs),
  .feedbackInputs(feedbackInputs), .sensorSupplyEn(sensorSupplyEn),
  .oscRunning(oscRunning), .selectedSlot(selectedSlot));
